//--- hw/timer8_pkg.sv
// Shared constants, register map and helper functions of the 8-bit compare timer
package timer8_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS  = 8'h00;
  localparam logic [7:0] COUNT_OFS = 8'h04;
  localparam logic [7:0] CMPA_OFS  = 8'h08;
  localparam logic [7:0] CMPB_OFS  = 8'h0C;
  localparam logic [7:0] FLAG_OFS  = 8'h10;
  localparam logic [7:0] IRQEN_OFS = 8'h14;
  localparam logic [7:0] FORCE_OFS = 8'h18;
  localparam logic [7:0] PORT_OFS  = 8'h1C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_WGM_LSB  = 0;
  localparam int CTRL_COMA_LSB = 4;
  localparam int CTRL_COMB_LSB = 6;
  localparam int FLAG_MATCH_A  = 0;
  localparam int FLAG_MATCH_B  = 1;
  localparam int FLAG_WRAP     = 2;
  localparam int PORT_VAL_LSB  = 0;
  localparam int PORT_DIR_LSB  = 2;

  // ----------------------------------------------------------------
  // Modes, actions, count limits and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0]  WGM_NORMAL    = 3'h0;
  localparam logic [2:0]  WGM_CTC       = 3'h2;
  localparam logic [2:0]  WGM_FAST_TOPA = 3'h7;
  localparam logic [1:0]  COM_NONE      = 2'h0;
  localparam logic [1:0]  COM_TOGGLE    = 2'h1;
  localparam logic [1:0]  COM_CLEAR     = 2'h2;
  localparam logic [1:0]  COM_SET       = 2'h3;
  localparam logic [7:0]  COUNT_MAX     = 8'hFF;
  localparam logic [7:0]  COUNT_BOTTOM  = 8'h00;
  localparam logic [7:0]  CMP_RST       = 8'h00;
  localparam logic [31:0] RDATA_ZERO    = 32'h0000_0000;

  // Odd mode codes are the PWM modes; they turn on double buffering
  function automatic logic isPwm(input logic [2:0] wgm);
    isPwm = wgm[0];
  endfunction : isPwm

  // New output state for a match or forced match under an action setting
  function automatic logic applyAction(input logic [1:0] com, input logic cur);
    unique case (com)
      COM_NONE:   applyAction = cur;
      COM_TOGGLE: applyAction = ~cur;
      COM_CLEAR:  applyAction = 1'b0;
      COM_SET:    applyAction = 1'b1;
    endcase
  endfunction : applyAction

endpackage : timer8_pkg

//--- hw/compare_chan_if.sv
// Signals between the timer core and one compare channel
`timescale 1ns/100ps
interface compare_chan_if;
  logic       tick;
  logic       block;
  logic [7:0] count;
  logic       pwm;
  logic [1:0] com;
  logic       forceHit;
  logic       wrEn;
  logic [7:0] wrData;
  logic       match;
  logic       flagSet;
  logic       outState;
  logic [7:0] readValue;

  modport core (output tick, block, count, pwm, com, forceHit, wrEn, wrData,
                input match, flagSet, outState, readValue);
  modport chan (input tick, block, count, pwm, com, forceHit, wrEn, wrData,
                output match, flagSet, outState, readValue);
endinterface : compare_chan_if

//--- hw/compare_channel.sv
// One compare channel: compare register with buffer, match detect, output state
`timescale 1ns/100ps
module compare_channel (
  // Clock and reset
  input wire logic         clk,
  input wire logic         rst,
  input wire logic         ce,
  // Core side
  compare_chan_if.chan     bus
);

  typedef struct packed {
    logic [7:0] cmpActive;
    logic [7:0] cmpBuffer;
    logic       outState;
    logic       matchSeen;
  } chan_s;

  chan_s st;
  chan_s next_st;

  assign bus.match     = (bus.count == st.cmpActive) && !bus.block;
  assign bus.flagSet   = bus.tick && st.matchSeen;
  assign bus.outState  = st.outState;
  assign bus.readValue = bus.pwm ? st.cmpBuffer : st.cmpActive;

  always_comb begin
    next_st = st;
    if (bus.tick) begin
      next_st.matchSeen = bus.match;
    end
    if (bus.wrEn) begin
      next_st.cmpBuffer = bus.wrData;
      if (!bus.pwm) begin
        next_st.cmpActive = bus.wrData;
      end
    end
    // Buffered value moves in at the bottom of the count
    if (bus.pwm && bus.tick && bus.count == timer8_pkg::COUNT_BOTTOM) begin
      next_st.cmpActive = st.cmpBuffer;
    end
    // Mode change never touches outState; in PWM modes outState is not updated by matches or forced matches
    if (!bus.pwm && ((bus.tick && bus.match) || bus.forceHit)) begin
      next_st.outState = timer8_pkg::applyAction(bus.com, st.outState);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  AST_FORCE_NO_FLAG: assert property (@(posedge clk) disable iff (rst)
    (ce && bus.forceHit && !bus.tick) |=> !st.matchSeen || $past(st.matchSeen))
    else $error("forced match disturbed match history");
  AST_COM_ZERO_HOLD: assert property (@(posedge clk) disable iff (rst)
    (ce && bus.com == timer8_pkg::COM_NONE) |=> st.outState == $past(st.outState))
    else $error("output state changed with action none");

endmodule : compare_channel

//--- hw/timer8_compare.sv
// 8-bit timer core: counter, two compare channels, flags, pin override, APB registers
//
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/100ps
module timer8_compare (
  // Clock, reset, enables
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        tmrTick,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Interrupt requests and service acknowledges
  input  wire logic [2:0]  intAck,
  output logic      [2:0]  intReq,
  // Port pin logic for the two channel pins
  output logic      [1:0]  pinOut,
  output logic      [1:0]  pinOe
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]      count;
    logic [2:0]      wgm;
    logic [1:0][1:0] com;
    logic [2:0]      flags;
    logic [2:0]      irqEn;
    logic [1:0]      portVal;
    logic [1:0]      portDir;
    logic            blockPending;
    logic            pready;
    logic [31:0]     prdata;
    logic            pslverr;
    logic [2:0]      irq;
    logic [1:0]      pinOut;
    logic [1:0]      pinOe;
    logic [1:0]      seenMatch;
  } core_s;

  core_s st;
  core_s next_st;

  logic       setup;
  logic       wrHit;
  logic       cntWr;
  logic       pwmMode;
  logic [2:0] flagSet;
  logic [2:0] flagClr;
  logic       wrapSet;

  compare_chan_if chan [2] ();

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  function automatic logic isMapped(input logic [7:0] a);
    isMapped = a inside {timer8_pkg::CTRL_OFS, timer8_pkg::COUNT_OFS, timer8_pkg::CMPA_OFS,
                         timer8_pkg::CMPB_OFS, timer8_pkg::FLAG_OFS, timer8_pkg::IRQEN_OFS,
                         timer8_pkg::FORCE_OFS, timer8_pkg::PORT_OFS};
  endfunction : isMapped

  function automatic logic wrAt(input logic hit, input logic [7:0] a, input logic [7:0] ofs);
    wrAt = hit && (a == ofs);
  endfunction : wrAt

  assign setup   = psel && !penable;
  // A write lands only at the edge that completes the access phase
  assign wrHit   = psel && penable && st.pready && pwrite;
  assign cntWr   = wrAt(wrHit, paddr, timer8_pkg::COUNT_OFS);
  assign pwmMode = timer8_pkg::isPwm(st.wgm);

  // ----------------------------------------------------------------
  // Compare channels
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : gen_chan
      assign chan[gi].tick   = tmrTick;
      // Blocking covers the write cycle itself and the following tick
      assign chan[gi].block  = st.blockPending || cntWr;
      assign chan[gi].count  = st.count;
      assign chan[gi].pwm    = pwmMode;
      assign chan[gi].com    = st.com[gi];
      assign chan[gi].forceHit = wrAt(wrHit, paddr, timer8_pkg::FORCE_OFS) && pwdata[gi];
      assign chan[gi].wrEn   = wrAt(wrHit, paddr, gi == 0 ? timer8_pkg::CMPA_OFS : timer8_pkg::CMPB_OFS);
      assign chan[gi].wrData = pwdata[7:0];

      compare_channel u_chan (
        .clk (clk),
        .rst (rst),
        .ce  (ce),
        .bus (chan[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    wrapSet = 1'b0;

    // Registered answer: pready rises in the first access cycle
    next_st.pready = setup;
    if (setup) begin
      next_st.pslverr = !isMapped(paddr);
      unique case (paddr)
        timer8_pkg::CTRL_OFS:  next_st.prdata = {24'h0000_00, st.com[1], st.com[0], 1'b0, st.wgm};
        timer8_pkg::COUNT_OFS: next_st.prdata = {24'h0000_00, st.count};
        timer8_pkg::CMPA_OFS:  next_st.prdata = {24'h0000_00, chan[0].readValue};
        timer8_pkg::CMPB_OFS:  next_st.prdata = {24'h0000_00, chan[1].readValue};
        timer8_pkg::FLAG_OFS:  next_st.prdata = {29'h0000_0000, st.flags};
        timer8_pkg::IRQEN_OFS: next_st.prdata = {29'h0000_0000, st.irqEn};
        timer8_pkg::PORT_OFS:  next_st.prdata = {28'h0000_000, st.portDir, st.portVal};
        default:               next_st.prdata = timer8_pkg::RDATA_ZERO;
      endcase
    end

    // Control registers
    if (wrAt(wrHit, paddr, timer8_pkg::CTRL_OFS)) begin
      next_st.wgm    = pwdata[timer8_pkg::CTRL_WGM_LSB +: 3];
      next_st.com[0] = pwdata[timer8_pkg::CTRL_COMA_LSB +: 2];
      next_st.com[1] = pwdata[timer8_pkg::CTRL_COMB_LSB +: 2];
    end
    if (wrAt(wrHit, paddr, timer8_pkg::IRQEN_OFS)) begin
      next_st.irqEn = pwdata[2:0];
    end
    if (wrAt(wrHit, paddr, timer8_pkg::PORT_OFS)) begin
      next_st.portVal = pwdata[timer8_pkg::PORT_VAL_LSB +: 2];
      next_st.portDir = pwdata[timer8_pkg::PORT_DIR_LSB +: 2];
    end

    // Counter; a CPU write overrides any count or clear
    if (cntWr) begin
      next_st.count        = pwdata[7:0];
      next_st.blockPending = 1'b1;
    end else if (tmrTick) begin
      next_st.blockPending = 1'b0;
      if ((st.wgm == timer8_pkg::WGM_CTC || st.wgm == timer8_pkg::WGM_FAST_TOPA) && chan[0].match) begin
        next_st.count = timer8_pkg::COUNT_BOTTOM;
      end else begin
        next_st.count = st.count + 8'h01;
      end
      wrapSet = (st.count == timer8_pkg::COUNT_MAX);
    end

    // Match history kept only for the flag timing checks
    if (tmrTick) begin
      next_st.seenMatch = {chan[1].match, chan[0].match};
    end

    // Sticky flags: hardware set wins over service or write-one clear
    flagSet = {wrapSet, chan[1].flagSet, chan[0].flagSet};
    flagClr = intAck;
    if (wrAt(wrHit, paddr, timer8_pkg::FLAG_OFS)) begin
      flagClr = flagClr | pwdata[2:0];
    end
    next_st.flags = (st.flags & ~flagClr) | flagSet;
    next_st.irq   = next_st.flags & next_st.irqEn;

    // Port override: direction stays with the port register
    // Interface arrays need constant indices, so the two pins are written out
    next_st.pinOut[0] = (next_st.com[0] != timer8_pkg::COM_NONE) ? chan[0].outState
                                                                 : next_st.portVal[0];
    next_st.pinOut[1] = (next_st.com[1] != timer8_pkg::COM_NONE) ? chan[1].outState
                                                                 : next_st.portVal[1];
    next_st.pinOe = next_st.portDir;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata  = st.prdata;
  assign pready  = st.pready;
  assign pslverr = st.pslverr;
  assign intReq  = st.irq;
  assign pinOut  = st.pinOut;
  assign pinOe   = st.pinOe;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_MATCH_EQUAL: assert property (
    chan[0].match |-> (st.count == chan[0].readValue || pwmMode))
    else $error("match A without equal count");

  AST_FLAG_ONE_TICK_LATER: assert property (
    (ce && tmrTick && st.seenMatch[1]) |=> st.flags[timer8_pkg::FLAG_MATCH_B])
    else $error("match B flag not set on following tick");

  AST_FLAG_A_NEXT_TICK: assert property (
    (ce && tmrTick && st.seenMatch[0]) |=> st.flags[timer8_pkg::FLAG_MATCH_A])
    else $error("match A flag not set on following tick");

  AST_IRQ_FROM_FLAGS: assert property (
    st.irq == (st.flags & st.irqEn))
    else $error("request does not follow flags and enables");

  AST_ACK_CLEARS: assert property (
    (ce && intAck[2] && !flagSet[2]) |=> !st.flags[timer8_pkg::FLAG_WRAP])
    else $error("service did not clear wrap flag");

  AST_W1C_CLEAR: assert property (
    (ce && wrAt(wrHit, paddr, timer8_pkg::FLAG_OFS) && pwdata[0] && !flagSet[0]) |=> !st.flags[0])
    else $error("write-one did not clear match A flag");

  AST_WRITE_BLOCKS: assert property (
    (ce && cntWr) |=> !chan[0].match && !chan[1].match)
    else $error("match seen right after counter write");

  AST_NORMAL_WRAP: assert property (
    (ce && tmrTick && !cntWr && st.wgm == timer8_pkg::WGM_NORMAL && st.count == timer8_pkg::COUNT_MAX)
    |=> st.count == timer8_pkg::COUNT_BOTTOM && st.flags[timer8_pkg::FLAG_WRAP])
    else $error("normal mode wrap or wrap flag wrong");

  AST_WRAP_ONLY_AT_MAX: assert property (
    (ce && tmrTick && !cntWr && st.count != timer8_pkg::COUNT_MAX && !st.flags[timer8_pkg::FLAG_WRAP])
    |=> !st.flags[timer8_pkg::FLAG_WRAP])
    else $error("wrap flag set away from MAX");

  AST_CTC_CLEAR: assert property (
    (ce && tmrTick && !cntWr && st.wgm == timer8_pkg::WGM_CTC && chan[0].match)
    |=> st.count == timer8_pkg::COUNT_BOTTOM)
    else $error("clear-on-match did not clear");

  AST_WRITE_PRIORITY: assert property (
    (ce && cntWr) |=> st.count == $past(pwdata[7:0]))
    else $error("counter write lost to count or clear");

  AST_HOLD_NO_TICK: assert property (
    (ce && !tmrTick && !cntWr) |=> $stable(st.count))
    else $error("counter moved without a tick");

  AST_SET_BEATS_CLEAR: assert property (
    (ce && flagSet[2]) |=> st.flags[2])
    else $error("wrap flag set lost");

  AST_PIN_OVERRIDE: assert property (
    (ce && st.com[0] != timer8_pkg::COM_NONE && next_st.com[0] == st.com[0])
    |=> st.pinOut[0] == $past(chan[0].outState) || $past(chan[0].forceHit) || $past(tmrTick))
    else $error("pin A not taken from output state");

  AST_PIN_DIR: assert property (
    st.pinOe == st.portDir)
    else $error("pin drive enable not from port direction");

  AST_PORT_VALUE: assert property (
    st.com[1] == timer8_pkg::COM_NONE |-> st.pinOut[1] == st.portVal[1])
    else $error("pin B not taken from port value");

  AST_CTC_MISSED_TOP: assert property (
    (ce && tmrTick && !cntWr && st.wgm == timer8_pkg::WGM_CTC && !chan[0].match
     && st.count != timer8_pkg::COUNT_MAX)
    |=> st.count == $past(st.count) + 8'h01)
    else $error("clear-on-match cleared without a match");

  AST_CTC_WRAP_FLAG: assert property (
    (ce && tmrTick && !cntWr && st.wgm == timer8_pkg::WGM_CTC && st.count == timer8_pkg::COUNT_MAX)
    |=> st.flags[timer8_pkg::FLAG_WRAP])
    else $error("clear-on-match wrap flag not set at MAX");

  AST_CE_FREEZE: assert property (
    !ce |=> $stable(st.count) && $stable(st.flags))
    else $error("state moved while clock enable low");

  AST_MODE_KEEPS_OUTPUT: assert property (
    (ce && wrAt(wrHit, paddr, timer8_pkg::CTRL_OFS) && !tmrTick && !chan[0].forceHit)
    |=> $stable(chan[0].outState))
    else $error("mode write disturbed output state");

  AST_FORCE_SETS: assert property (
    (ce && chan[0].forceHit && !pwmMode && st.com[0] == timer8_pkg::COM_SET) |=> chan[0].outState)
    else $error("forced match did not apply set action");

  AST_FORCE_NO_FLAG_A: assert property (
    (ce && chan[0].forceHit && !tmrTick && !st.flags[timer8_pkg::FLAG_MATCH_A])
    |=> !st.flags[timer8_pkg::FLAG_MATCH_A])
    else $error("forced match set flag A");

  COV_CTC_TOGGLE: cover property (
    st.wgm == timer8_pkg::WGM_CTC && st.com[0] == timer8_pkg::COM_TOGGLE && ce && tmrTick && chan[0].match);
  COV_NORMAL_WRAP: cover property (ce && wrapSet && st.wgm == timer8_pkg::WGM_NORMAL);
  COV_FORCE: cover property (ce && chan[1].forceHit);
  COV_CE_LOW_TICK: cover property (!ce && tmrTick);
  COV_SET_AND_CLEAR: cover property (ce && flagSet[0] && flagClr[0]);

endmodule : timer8_compare

//--- tb/irq_service_model.sv
// Interrupt service model standing in for the CPU on the request lines
`timescale 1ns/100ps
module irq_service_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Service control
  input  wire logic       enable,
  input  wire logic [3:0] latency,
  // Request and service lines
  input  wire logic [2:0] intReq,
  output logic      [2:0] intAck
);
  logic [3:0] waitCnt;

  // Lowest source first; a fresh wait after each service lets the request drop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      waitCnt <= 4'h0;
      intAck  <= 3'h0;
    end else if (!enable || intReq == 3'h0 || intAck != 3'h0) begin
      waitCnt <= 4'h0;
      intAck  <= 3'h0;
    end else if (waitCnt >= latency) begin
      waitCnt <= 4'h0;
      intAck  <= intReq & (~intReq + 3'h1);
    end else begin
      waitCnt <= waitCnt + 4'h1;
    end
  end
endmodule : irq_service_model

//--- tb/timer8_compare_normal_ctc_tb_top.sv
// Self-checking bench for the 8-bit compare timer
`timescale 1ns/100ps
module timer8_compare_normal_ctc_tb_top;
  logic        clk = 1'b0, rst = 1'b1, ce = 1'b1, tmrTick = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, svcOn = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rdata;
  logic        pready, pslverr, lastErr;
  logic [2:0]  intAck, intReq;
  logic [1:0]  pinOut, pinOe;
  logic [3:0]  svcLatency = 4'h3;
  int          nFail = 0;
  int          nCompared = 0;

  always #12.5 clk = ~clk;

  timer8_compare dut_u (
    .clk(clk), .rst(rst), .ce(ce), .tmrTick(tmrTick),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .intAck(intAck), .intReq(intReq), .pinOut(pinOut), .pinOe(pinOe)
  );

  irq_service_model svc_u (
    .clk(clk), .rst(rst), .enable(svcOn), .latency(svcLatency), .intReq(intReq), .intAck(intAck)
  );

  // ----------------------------------------------------------------
  // Bus, timer and compare tasks
  // ----------------------------------------------------------------
  task automatic completeRun();
    $display("comparisons %0d, mismatches %0d", nCompared, nFail);
    if (nFail == 0 && nCompared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : completeRun

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    nCompared++;
    if (seen !== exp) begin
      nFail++;
      $display("unexpected at %0t ns: %s, seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  // Request is held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= data;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      nFail++;
      $display("unexpected at %0t ns: no ready", $time);
      completeRun();
    end
    rdata   = prdata;
    lastErr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    apb(1'b1, addr, data);
  endtask : wr

  task automatic rdChk(input logic [7:0] addr, input logic [31:0] exp, input string what);
    apb(1'b0, addr, 32'h0000_0000);
    chk(rdata, exp, what);
  endtask : rdChk

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      tmrTick <= 1'b1;
    end
    @(posedge clk);
    tmrTick <= 1'b0;
  endtask : tick

  // Pins are registered one clock behind the output state
  task automatic pinChk(input logic [3:0] exp, input string what);
    repeat (2) @(posedge clk);
    chk({28'h000_0000, pinOe, pinOut}, {28'h000_0000, exp}, what);
  endtask : pinChk

  function automatic logic [31:0] ctrl(input logic [2:0] w, input logic [1:0] a, input logic [1:0] b);
    ctrl = {24'h00_0000, b, a, 1'b0, w};
  endfunction : ctrl

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rdChk(timer8_pkg::CTRL_OFS, 32'h0000_0000, "ctrl at reset");
    rdChk(timer8_pkg::FLAG_OFS, 32'h0000_0000, "flags at reset");
    pinChk(4'h0, "pins at reset");
    rdChk(8'h20, 32'h0000_0000, "unmapped read");
    chk({31'h0000_0000, lastErr}, 32'h0000_0001, "unmapped error");
    $display("done reset");
    wr(timer8_pkg::COUNT_OFS, 32'h0000_00FD);
    tick(2);
    rdChk(timer8_pkg::COUNT_OFS, 32'h0000_00FF, "count at max");
    rdChk(timer8_pkg::FLAG_OFS, 32'h0000_0000, "no early wrap");
    tick(1);
    rdChk(timer8_pkg::COUNT_OFS, 32'h0000_0000, "count wrapped");
    rdChk(timer8_pkg::FLAG_OFS, 32'h0000_0004, "wrap flag");
    wr(timer8_pkg::FLAG_OFS, 32'h0000_0000);
    rdChk(timer8_pkg::FLAG_OFS, 32'h0000_0004, "zero write keeps");
    wr(timer8_pkg::FLAG_OFS, 32'h0000_0004);
    rdChk(timer8_pkg::FLAG_OFS, 32'h0000_0000, "one write clears");
    $display("done normal");
    wr(timer8_pkg::CMPA_OFS, 32'h0000_0012);
    wr(timer8_pkg::CMPB_OFS, 32'h0000_0012);
    wr(timer8_pkg::CTRL_OFS, ctrl(timer8_pkg::WGM_NORMAL, timer8_pkg::COM_TOGGLE, timer8_pkg::COM_NONE));
    wr(timer8_pkg::PORT_OFS, 32'h0000_0003);
    pinChk(4'h2, "override A only");
    wr(timer8_pkg::COUNT_OFS, 32'h0000_0012);
    tick(3);
    rdChk(timer8_pkg::FLAG_OFS, 32'h0000_0000, "match blocked");
    pinChk(4'h2, "blocked no toggle");
    wr(timer8_pkg::COUNT_OFS, 32'h0000_0010);
    tick(2);
    rdChk(timer8_pkg::FLAG_OFS, 32'h0000_0000, "flag one tick late");
    tick(2);
    rdChk(timer8_pkg::FLAG_OFS, 32'h0000_0003, "both flags");
    pinChk(4'h3, "A toggled");
    wr(timer8_pkg::CTRL_OFS, ctrl(timer8_pkg::WGM_NORMAL, timer8_pkg::COM_TOGGLE, timer8_pkg::COM_TOGGLE));
    pinChk(4'h1, "action at once");
    wr(timer8_pkg::COUNT_OFS, 32'h0000_0011);
    tick(3);
    pinChk(4'h2, "both toggled");
    $display("done compare");
    wr(timer8_pkg::FLAG_OFS, 32'h0000_0001);
    rdChk(timer8_pkg::FLAG_OFS, 32'h0000_0002, "clear A only");
    wr(timer8_pkg::IRQEN_OFS, 32'h0000_0002);
    repeat (2) @(posedge clk);
    chk({29'h0000_0000, intReq}, 32'h0000_0002, "request B");
    svcOn <= 1'b1;
    repeat (12) @(posedge clk);
    rdChk(timer8_pkg::FLAG_OFS, 32'h0000_0000, "serviced B");
    svcOn <= 1'b0;
    $display("done service");
    wr(timer8_pkg::CTRL_OFS, ctrl(timer8_pkg::WGM_NORMAL, timer8_pkg::COM_SET, timer8_pkg::COM_CLEAR));
    wr(timer8_pkg::FORCE_OFS, 32'h0000_0003);
    pinChk(4'h1, "forced states");
    rdChk(timer8_pkg::COUNT_OFS, 32'h0000_0014, "force keeps count");
    rdChk(timer8_pkg::FLAG_OFS, 32'h0000_0000, "force no flag");
    wr(timer8_pkg::PORT_OFS, 32'h0000_000C);
    pinChk(4'hD, "direction from port");
    $display("done force");
    wr(timer8_pkg::CTRL_OFS, ctrl(timer8_pkg::WGM_CTC, timer8_pkg::COM_TOGGLE, timer8_pkg::COM_NONE));
    pinChk(4'hD, "state kept");
    wr(timer8_pkg::CMPA_OFS, 32'h0000_0003);
    wr(timer8_pkg::CMPB_OFS, 32'h0000_0003);
    wr(timer8_pkg::COUNT_OFS, 32'h0000_0000);
    tick(3);
    rdChk(timer8_pkg::COUNT_OFS, 32'h0000_0003, "count at top");
    tick(1);
    rdChk(timer8_pkg::COUNT_OFS, 32'h0000_0000, "cleared after top");
    pinChk(4'hC, "toggle at top");
    tick(4);
    pinChk(4'hD, "toggle each period");
    wr(timer8_pkg::COUNT_OFS, 32'h0000_0005);
    wr(timer8_pkg::FLAG_OFS, 32'h0000_0007);
    tick(250);
    rdChk(timer8_pkg::COUNT_OFS, 32'h0000_00FF, "ran past top");
    rdChk(timer8_pkg::FLAG_OFS, 32'h0000_0003, "no wrap flag yet");
    tick(1);
    rdChk(timer8_pkg::FLAG_OFS, 32'h0000_0007, "wrap at 00");
    tick(5);
    rdChk(timer8_pkg::COUNT_OFS, 32'h0000_0001, "cleared at top");
    wr(timer8_pkg::IRQEN_OFS, 32'h0000_0004);
    svcLatency <= 4'hC;
    svcOn      <= 1'b1;
    repeat (30) @(posedge clk);
    rdChk(timer8_pkg::FLAG_OFS, 32'h0000_0003, "slow service");
    svcOn <= 1'b0;
    ce    <= 1'b0;
    tick(3);
    ce    <= 1'b1;
    rdChk(timer8_pkg::COUNT_OFS, 32'h0000_0001, "frozen while disabled");
    $display("done clear on match");
    @(posedge clk);
    rst <= 1'b1;
    pinChk(4'h0, "reset clears state");
    rst <= 1'b0;
    rdChk(timer8_pkg::CTRL_OFS, 32'h0000_0000, "ctrl after reset");
    $display("done second reset");
    completeRun();
  end
endmodule : timer8_compare_normal_ctc_tb_top
